//--- design/amp_pkg.sv
// Purpose: shared constants and carriers for the async memory port
// Assumes: 200 MHz core clock
// Notes:   bank map by upper address bits
package amp_pkg;
  localparam int           AMP_ADDR_W     = 24;
  localparam int           AMP_DATA_W     = 8;
  localparam int           AMP_BANKS      = 4;
  localparam int           AMP_BANK_LSB   = 22;
  localparam logic [23:0]  AMP_ADDR_RST   = 24'h000000;
  localparam logic [7:0]   AMP_DATA_RST   = 8'h00;
  localparam logic [3:0]   AMP_SEL_IDLE   = 4'hF;
  localparam logic [3:0]   AMP_MIN_STROBE = 4'h1;

  typedef struct packed {
    logic        write;
    logic        cond;
    logic [23:0] addr;
    logic [7:0]  wdata;
  } amp_req_s;

  typedef struct packed {
    logic        flag_mode2;
    logic        flag_mode3;
  } amp_pinmode_s;

  typedef enum logic [3:0] {
    AMP_IDLE   = 4'h1,
    AMP_STROBE = 4'h2,
    AMP_WAIT   = 4'h4,
    AMP_GAP    = 4'h8
  } amp_state_e;
endpackage

//--- design/amp_skid_buf.sv
// Purpose: two-entry buffer with valid/ready on both sides
// Assumes: single clock
// Notes:   full and empty are exact
`timescale 1ns/1ps
module amp_skid_buf
  import amp_pkg::*;
#(
  parameter int W = 8
)(
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_valid,
  output logic              o_ready,
  input  wire logic [W-1:0] i_data,
  output logic              o_valid,
  input  wire logic         i_ready,
  output logic [W-1:0]      o_data
);
  logic [W-1:0] mem_reg [2];
  logic         wr_ptr_reg;
  logic         rd_ptr_reg;
  logic [1:0]   cnt_reg;
  logic         push;
  logic         pop;

  assign push    = i_valid && (cnt_reg != 2'h2);
  assign pop     = i_ready && (cnt_reg != 2'h0);
  assign o_ready = (cnt_reg != 2'h2);
  assign o_valid = (cnt_reg != 2'h0);
  assign o_data  = mem_reg[rd_ptr_reg];

  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      cnt_reg    <= 2'h0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= ~wr_ptr_reg;
      if (pop)
        rd_ptr_reg <= ~rd_ptr_reg;
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end

  always_ff @(posedge i_clk)
    if (push)
      mem_reg[wr_ptr_reg] <= i_data;
endmodule

//--- design/amp_port.sv
// Purpose: external asynchronous memory port pin logic
// Assumes: requests and read data consumer on the core clock
// Notes:   one access at a time, at least two idle cycles between accesses
//
// Behaviour
// RULE_01 - access stays open while acknowledge input is held low
// RULE_02 - bank selects are active low chip selects, banks zero and one
// RULE_03 - bank selects change in the same cycle as address outputs
// RULE_04 - all bank selects high when no access is in progress
// RULE_05 - conditional access asserts select only when condition is true
// RULE_06 - read strobe low for every external read word only
// RULE_07 - external address presented on 24-bit output bus
// RULE_08 - 8-bit data bus driven on writes, sampled on reads, released otherwise
// RULE_09 - after reset address pins in memory mode, flag pins in flag mode
// RULE_10 - after reset data pins in memory interface mode
// RULE_11 - parallel input control makes channel zero sample address pins
// RULE_12 - write strobe low whenever a word is written
// RULE_13 - banks two and three selects on flag pins two and three
// RULE_14 - address, select and write data stable while strobe asserted
// RULE_15 - never both strobes, one strobe per access, gap between accesses
`timescale 1ns/1ps
module amp_port
  import amp_pkg::*;
(
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  input  wire logic                  i_req_valid,
  input  wire amp_req_s              i_req,
  output logic                       o_req_ready,
  output logic                       o_rd_valid,
  input  wire logic                  i_rd_ready,
  output logic [AMP_DATA_W-1:0]      o_rd_data,
  input  wire logic                  i_parallel_input_ctrl,
  input  wire amp_pinmode_s          i_pinmode,
  output logic                       o_pdi_valid,
  output logic [AMP_ADDR_W-1:0]      o_pdi_word,
  input  wire logic                  i_ext_wait_ack_in,
  input  wire logic [AMP_ADDR_W-1:0] i_ext_addr_in,
  output logic [AMP_ADDR_W-1:0]      o_ext_addr_out,
  output logic [AMP_ADDR_W-1:0]      o_ext_addr_oe,
  input  wire logic [AMP_DATA_W-1:0] i_ext_data_io,
  output logic [AMP_DATA_W-1:0]      o_ext_data_io,
  output logic                       o_ext_data_oe,
  output logic [1:0]                 o_bank_select_n,
  output logic [3:2]                 o_flag_out,
  output logic [3:2]                 o_flag_oe,
  output logic                       o_read_strobe_n,
  output logic                       o_write_strobe_n
);
  // ==================================================
  // input synchronisers
  logic [1:0]            ack_sync_reg;
  logic [AMP_ADDR_W-1:0] pa1_reg;
  logic [AMP_ADDR_W-1:0] pa2_reg;
  logic [AMP_DATA_W-1:0] pd1_reg;
  logic [AMP_DATA_W-1:0] pd2_reg;
  logic                  pdi_en_reg;
  logic                  ack;

  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      ack_sync_reg <= 2'h3;
      pa1_reg      <= AMP_ADDR_RST;
      pa2_reg      <= AMP_ADDR_RST;
      pd1_reg      <= AMP_DATA_RST;
      pd2_reg      <= AMP_DATA_RST;
    end
    else
    begin
      ack_sync_reg <= {ack_sync_reg[0], i_ext_wait_ack_in};
      pa1_reg      <= i_ext_addr_in;
      pa2_reg      <= pa1_reg;
      pd1_reg      <= i_ext_data_io;
      pd2_reg      <= pd1_reg;
    end
  assign ack = ack_sync_reg[1];

  // ==================================================
  // access sequencer
  amp_state_e            st_reg;
  amp_req_s              cur_reg;
  logic [3:0]            sel_n_reg;
  logic                  rd_n_reg;
  logic                  wr_n_reg;
  logic                  doe_reg;
  logic                  rd_push_reg;
  logic [AMP_DATA_W-1:0] rd_cap_reg;
  logic                  buf_ready;
  logic                  take;
  logic [3:0]            sel_dec;
  logic [3:0]            strobe_cnt_reg;

  // reads wait for buffer room so no returned word is lost
  assign take        = (st_reg == AMP_IDLE) && i_req_valid && !pdi_en_reg && (i_req.write || buf_ready);
  assign o_req_ready = (st_reg == AMP_IDLE) && !pdi_en_reg && buf_ready;
  assign sel_dec     = i_req.cond ? ~(4'h1 << i_req.addr[AMP_BANK_LSB +: 2]) : AMP_SEL_IDLE; // [RULE_05]

  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      st_reg      <= AMP_IDLE;
      cur_reg     <= '0;
      sel_n_reg   <= AMP_SEL_IDLE; // [RULE_04]
      rd_n_reg    <= 1'b1;
      wr_n_reg    <= 1'b1;
      doe_reg     <= 1'b0;
      rd_push_reg <= 1'b0;
      rd_cap_reg  <= AMP_DATA_RST;
    end
    else
    begin
      rd_push_reg <= 1'b0;
      unique case (st_reg)
        AMP_IDLE:
          if (take)
          begin
            cur_reg   <= i_req;             // [RULE_07] [RULE_14]
            sel_n_reg <= sel_dec;           // [RULE_02] [RULE_03] [RULE_13]
            rd_n_reg  <= i_req.write;       // [RULE_06] [RULE_15]
            wr_n_reg  <= !i_req.write;      // [RULE_12] [RULE_15]
            doe_reg   <= i_req.write;       // [RULE_08]
            st_reg    <= AMP_STROBE;
          end
        AMP_STROBE:
          if (strobe_cnt_reg == AMP_MIN_STROBE) // [RULE_01]
            st_reg <= AMP_WAIT;
        AMP_WAIT:
          if (ack)                          // [RULE_01]
          begin
            rd_cap_reg  <= pd2_reg;         // [RULE_08]
            rd_push_reg <= !cur_reg.write;
            sel_n_reg   <= AMP_SEL_IDLE;    // [RULE_04]
            rd_n_reg    <= 1'b1;
            wr_n_reg    <= 1'b1;
            doe_reg     <= 1'b0;
            st_reg      <= AMP_GAP;         // [RULE_15]
          end
        AMP_GAP:
          st_reg <= AMP_IDLE;
      endcase
    end

  // strobe settle count: the ack synchroniser must have seen the pin during this access
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
      strobe_cnt_reg <= 4'h0;
    else if (st_reg == AMP_STROBE)
      strobe_cnt_reg <= strobe_cnt_reg + 4'h1;
    else
      strobe_cnt_reg <= 4'h0;

  // ==================================================
  // pin mode and parallel input channel
  logic aoe_reg;
  logic pdi_v_reg;
  logic [AMP_ADDR_W-1:0] pdi_w_reg;
  logic [1:0]            pdi_rel_reg;
  logic [3:2]            flag_oe_reg;

  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      pdi_en_reg <= 1'b0;                   // [RULE_09] [RULE_10]
      aoe_reg    <= 1'b0;
      pdi_v_reg  <= 1'b0;
      pdi_w_reg  <= AMP_ADDR_RST;
      pdi_rel_reg <= 2'h0;
      flag_oe_reg <= 2'h0;                  // [RULE_09]
    end
    else
    begin
      if (st_reg == AMP_IDLE)
        pdi_en_reg <= i_parallel_input_ctrl; // [RULE_11]
      aoe_reg   <= !pdi_en_reg;
      // valid only once the synchronised word was sampled with the address drivers off
      pdi_rel_reg <= {pdi_rel_reg[0], !aoe_reg};
      pdi_v_reg <= pdi_rel_reg[1] && pdi_en_reg; // [RULE_11]
      pdi_w_reg <= pa2_reg;                  // [RULE_11]
      flag_oe_reg <= {i_pinmode.flag_mode3, i_pinmode.flag_mode2} & {2{!pdi_en_reg}}; // [RULE_13]
    end

  assign o_ext_addr_out   = cur_reg.addr;
  assign o_ext_addr_oe    = {AMP_ADDR_W{aoe_reg}};
  assign o_ext_data_io    = cur_reg.wdata;
  assign o_ext_data_oe    = doe_reg;
  assign o_bank_select_n  = sel_n_reg[1:0];
  assign o_flag_out       = sel_n_reg[3:2];
  assign o_flag_oe        = flag_oe_reg;
  assign o_read_strobe_n  = rd_n_reg;
  assign o_write_strobe_n = wr_n_reg;
  assign o_pdi_valid      = pdi_v_reg;
  assign o_pdi_word       = pdi_w_reg;

  amp_skid_buf #(.W(AMP_DATA_W)) u_rd_buf (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_valid (rd_push_reg),
    .o_ready (buf_ready),
    .i_data  (rd_cap_reg),
    .o_valid (o_rd_valid),
    .i_ready (i_rd_ready),
    .o_data  (o_rd_data)
  );

  // ==================================================
  // checks
  a_strobe_excl: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !(!rd_n_reg && !wr_n_reg)) else $error("both strobes low"); // [RULE_15]
  a_idle_sel: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (rd_n_reg && wr_n_reg) |-> sel_n_reg == AMP_SEL_IDLE) else $error("select active when idle"); // [RULE_04]
  a_ack_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_reg == AMP_WAIT && !ack) |=> (st_reg == AMP_WAIT)) else $error("access ended under wait"); // [RULE_01]
  a_addr_stable: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!rd_n_reg || !wr_n_reg) && $past(!rd_n_reg || !wr_n_reg) |-> $stable(cur_reg))
    else $error("addr moved"); // [RULE_14]
  a_strobe_settle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_reg == AMP_STROBE && strobe_cnt_reg != AMP_MIN_STROBE) |=> (st_reg == AMP_STROBE))
    else $error("wait sampled too early"); // [RULE_01]
  a_pdi_released: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    pdi_v_reg |-> !aoe_reg) else $error("parallel word while driving"); // [RULE_11]
  a_gap_after: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(wr_n_reg && rd_n_reg) |-> ##1 (rd_n_reg && wr_n_reg)) else $error("no idle gap"); // [RULE_15]
  a_data_drive: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    doe_reg == !wr_n_reg) else $error("data drive mismatch"); // [RULE_08]
  a_cond_false: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (take && !i_req.cond) |=> sel_n_reg == AMP_SEL_IDLE) else $error("false cond selected"); // [RULE_05]
  a_rd_push: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_reg == AMP_WAIT && ack && !cur_reg.write) |=> rd_push_reg) else $error("read word lost"); // [RULE_06]
endmodule

//--- test/amp_ext_mem.sv
// Purpose: external asynchronous memory model for the port
// Assumes: core clock, pull-up on the data pins
// Notes:   acknowledge held low for i_wait cycles of each access
`timescale 1ns/1ps
module amp_ext_mem
(
  input  wire logic        i_clk,
  input  wire logic        i_rd_n,
  input  wire logic        i_wr_n,
  input  wire logic [23:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic [7:0]  i_wait,
  output logic             o_ack,
  output logic [7:0]       o_rdata
);
  logic [7:0] mem [0:255];
  logic [7:0] cnt_reg;
  // ==========================================
  // wait states
  always_ff @(posedge i_clk)
    cnt_reg <= (i_rd_n && i_wr_n) ? 8'h00 : cnt_reg + 8'h01;
  assign o_ack = (i_rd_n && i_wr_n) || (cnt_reg >= i_wait);
  // ==========================================
  // storage, pull-up level when not read
  always_ff @(posedge i_clk)
    if (!i_wr_n) mem[i_addr[7:0]] <= i_wdata;
  assign o_rdata = i_rd_n ? 8'hFF : mem[i_addr[7:0]];
endmodule

//--- test/amp_port_test.sv
// Purpose: self-checking bench for the async memory port
// Assumes: 200 MHz clock, memory model on the pins
// Notes:   scenarios are tasks run in sequence
`timescale 1ns/1ps
module amp_port_test;
  import amp_pkg::*;
`define CHK(a, e, m) \
  begin \
    num_checks++; \
    if ((a) !== (e)) \
    begin \
      bad_count++; \
      $display("wrong value t=%0t %s", $time, m); \
    end \
  end
  logic i_clk, i_rst_n, i_req_valid, i_rd_ready, i_parallel_input_ctrl;
  amp_req_s i_req;
  amp_pinmode_s i_pinmode;
  logic [23:0] pdi_src, o_ext_addr_out, o_ext_addr_oe, o_pdi_word;
  logic [7:0] wait_cyc, mem_rdata, o_rd_data, o_ext_data_io;
  logic [1:0] o_bank_select_n, o_flag_out, o_flag_oe;
  logic ack, o_req_ready, o_rd_valid, o_pdi_valid, o_ext_data_oe, o_read_strobe_n, o_write_strobe_n;
  int bad_count = 0;
  int num_checks = 0;
  // ==========================================
  // pins and parts
  amp_port u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req_valid(i_req_valid), .i_req(i_req),
    .o_req_ready(o_req_ready), .o_rd_valid(o_rd_valid), .i_rd_ready(i_rd_ready), .o_rd_data(o_rd_data),
    .i_parallel_input_ctrl(i_parallel_input_ctrl), .i_pinmode(i_pinmode), .o_pdi_valid(o_pdi_valid),
    .o_pdi_word(o_pdi_word), .i_ext_wait_ack_in(ack),
    .i_ext_addr_in((o_ext_addr_oe & o_ext_addr_out) | (~o_ext_addr_oe & pdi_src)),
    .o_ext_addr_out(o_ext_addr_out), .o_ext_addr_oe(o_ext_addr_oe),
    .i_ext_data_io(o_ext_data_oe ? o_ext_data_io : mem_rdata), .o_ext_data_io(o_ext_data_io),
    .o_ext_data_oe(o_ext_data_oe), .o_bank_select_n(o_bank_select_n), .o_flag_out(o_flag_out),
    .o_flag_oe(o_flag_oe), .o_read_strobe_n(o_read_strobe_n), .o_write_strobe_n(o_write_strobe_n));
  amp_ext_mem u_mem (.i_clk(i_clk), .i_rd_n(o_read_strobe_n), .i_wr_n(o_write_strobe_n),
    .i_addr(o_ext_addr_out), .i_wdata(o_ext_data_io), .i_wait(wait_cyc), .o_ack(ack), .o_rdata(mem_rdata));
  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // ==========================================
  // helpers
  task automatic step;
    @(posedge i_clk);
    #1;
  endtask
  task automatic results;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
    begin
      $display("ALL TESTS PASSED");
    end
    else
    begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic tmo(input int i);
    if (i >= 50)
    begin
      bad_count++;
      results();
    end
  endtask
  task automatic access(input logic w, input logic c, input logic [23:0] a, input logic [7:0] d,
                        input logic [7:0] wt);
    int i;
    int n;
    logic [3:0] sel;
    wait_cyc = wt;
    i_req = '{w, c, a, d};
    i_req_valid = 1'b1;
    for (i = 0; i < 50 && o_req_ready !== 1'b1; i++) step();
    tmo(i);
    step();
    i_req_valid = 1'b0;
    for (i = 0; i < 50 && (o_read_strobe_n & o_write_strobe_n); i++) step();
    tmo(i);
    sel = c ? ~(4'h1 << a[23:22]) : 4'hF;
    for (n = 0; n < 300 && !(o_read_strobe_n & o_write_strobe_n); n++)
    begin
      `CHK(o_read_strobe_n, w, "read strobe")
      `CHK(o_write_strobe_n, !w, "write strobe")
      `CHK(o_ext_addr_out, a, "address")
      `CHK({o_flag_out, o_bank_select_n}, sel, "select")
      `CHK(o_ext_data_oe, w, "data drive")
      if (w) `CHK(o_ext_data_io, d, "write data")
      step();
    end
    tmo(n >= 300 ? 50 : 0);
    `CHK(n > wt, 1'b1, "wait states")
    `CHK({o_flag_out, o_bank_select_n}, 4'hF, "idle select")
  endtask
  task automatic pop(input logic [7:0] e);
    int i;
    for (i = 0; i < 50 && o_rd_valid !== 1'b1; i++) step();
    tmo(i);
    `CHK(o_rd_data, e, "read data")
    i_rd_ready = 1'b1;
    step();
    i_rd_ready = 1'b0;
    step();
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset;
    step();
    step();
    `CHK(o_ext_addr_oe, 24'hFFFFFF, "address mode")
    `CHK(o_flag_oe, 2'h0, "flag mode")
    `CHK(o_ext_data_oe, 1'b0, "data mode")
    `CHK({o_flag_out, o_bank_select_n}, 4'hF, "reset select")
    i_pinmode = 2'h3;
  endtask
  task automatic t_banks;
    for (int b = 0; b < 4; b++) access(1'b1, 1'b1, 24'(b << 22) | 24'hA0 | 24'(b), 8'h5A ^ 8'(b), 8'(3 * b));
    access(1'b1, 1'b0, 24'h4000F0, 8'h11, 8'h00);
    for (int b = 0; b < 4; b++)
    begin
      access(1'b0, 1'b1, 24'(b << 22) | 24'hA0 | 24'(b), 8'h00, 8'(7 - b));
      pop(8'h5A ^ 8'(b));
    end
  endtask
  task automatic t_buffer;
    access(1'b0, 1'b1, 24'h0000A1, 8'h00, 8'h00);
    access(1'b0, 1'b1, 24'h4000A2, 8'h00, 8'h02);
    step();
    `CHK(o_req_ready, 1'b0, "buffer full")
    pop(8'h5B);
    pop(8'h58);
  endtask
  task automatic t_pdi;
    int i;
    i_parallel_input_ctrl = 1'b1;
    pdi_src = 24'hC3A51E;
    for (i = 0; i < 50 && o_pdi_valid !== 1'b1; i++) step();
    tmo(i);
    `CHK(o_pdi_word, 24'hC3A51E, "parallel word")
    `CHK(o_ext_addr_oe, 24'h000000, "address released")
    `CHK(o_req_ready, 1'b0, "port refuses")
    i_parallel_input_ctrl = 1'b0;
    access(1'b1, 1'b1, 24'h0000B0, 8'hE7, 8'h01);
    `CHK(o_pdi_valid, 1'b0, "parallel input off")
    `CHK(o_flag_oe, 2'h3, "flag select mode")
  endtask
  initial
  begin
    i_rst_n = 1'b0;
    i_req_valid = 1'b0;
    i_req = '0;
    i_rd_ready = 1'b0;
    i_parallel_input_ctrl = 1'b0;
    i_pinmode = 2'h0;
    pdi_src = 24'h000000;
    wait_cyc = 8'h00;
    repeat (8) @(posedge i_clk);
    #1;
    i_rst_n = 1'b1;
    t_reset();
    t_banks();
    t_buffer();
    t_pdi();
    results();
  end
endmodule
